// ### logic/two_wire_pkg.sv
// shared constants and types of the two-wire bus controller
package two_wire_pkg;
   localparam int CLK_MHZ = 100;
   // bit rates of the two speed grades
   localparam int STD_RATE_KBPS = 100;
   localparam int FAST_RATE_KBPS = 400;
   localparam int STD_BIT_NS = 1000000 / STD_RATE_KBPS;
   localparam int FAST_BIT_NS = 1000000 / FAST_RATE_KBPS;
   // each low and high phase is half a bit; least times round up
   localparam int STD_HALF_NS = STD_BIT_NS / 2;
   localparam int FAST_HALF_NS = FAST_BIT_NS / 2;
   localparam int CNT_W = 10;
   localparam logic [CNT_W-1:0] STD_HALF_CYC =
      CNT_W'((STD_HALF_NS * CLK_MHZ + 999) / 1000);
   localparam logic [CNT_W-1:0] FAST_HALF_CYC =
      CNT_W'((FAST_HALF_NS * CLK_MHZ + 999) / 1000);
   localparam logic [3:0] BYTE_LAST_BIT = 4'h7;
   localparam logic [3:0] ACK_BIT = 4'h8;
   localparam logic [6:0] GEN_CALL_ADDR = 7'h00;
   typedef enum logic [1:0] {
      OP_START,
      OP_WRITE,
      OP_READ,
      OP_STOP
   } op_e;
endpackage

// ### logic/pin_sync.sv
// three-stage pin synchroniser with agreement filter
module pin_sync (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic pin_in,
   output logic level_out
);
   logic s1_ff, s2_ff, s3_ff, level_ff;

   // idle bus level is high, so all stages reset high
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         s1_ff <= 1'b1;
         s2_ff <= 1'b1;
         s3_ff <= 1'b1;
         level_ff <= 1'b1;
      end else begin
         s1_ff <= pin_in;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         if (s2_ff == s3_ff) begin
            level_ff <= s3_ff;
         end
      end
   end

   assign level_out = level_ff;
endmodule

// ### logic/two_wire_ctrl.sv
// two-wire bus master and slave participant facing the documented controller
module two_wire_ctrl
   import two_wire_pkg::*;
(
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe_out,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   input wire logic fast_mode_in,
   input wire logic cmd_valid_in,
   output logic cmd_ready_out,
   input wire op_e cmd_op_in,
   input wire logic [7:0] cmd_data_in,
   input wire logic cmd_nack_in,
   output logic rsp_valid_out,
   output logic [7:0] rsp_data_out,
   output logic rsp_nack_out,
   output logic arb_lost_out,
   output logic bus_busy_out,
   input wire logic [6:0] own_addr_in,
   output logic slave_rx_valid_out,
   output logic [7:0] slave_rx_data_out,
   input wire logic slave_rx_accept_in,
   input wire logic slave_hold_in,
   input wire logic [7:0] slave_tx_data_in,
   output logic slave_tx_req_out
);
   typedef enum logic [3:0] {
      M_IDLE, M_START, M_WAIT, M_LOW, M_HIGH, M_RSTART, M_STOP_LOW, M_STOP_HIGH, M_STOP_END
   } mst_e;
   typedef enum logic [2:0] {S_IDLE, S_ADDR, S_RX, S_TX, S_SKIP} slv_e;

   logic scl_s, sda_s, scl_prev_ff, sda_prev_ff;
   logic start_det, stop_det, scl_rise, scl_fall;
   pin_sync u_scl_sync (.clk_in(clk_in), .reset_in(reset_in), .pin_in(scl_in), .level_out(scl_s));
   pin_sync u_sda_sync (.clk_in(clk_in), .reset_in(reset_in), .pin_in(sda_in), .level_out(sda_s));

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         scl_prev_ff <= 1'b1;
         sda_prev_ff <= 1'b1;
      end else begin
         scl_prev_ff <= scl_s;
         sda_prev_ff <= sda_s;
      end
   end

   assign start_det = scl_s && scl_prev_ff && sda_prev_ff && !sda_s;
   assign stop_det = scl_s && scl_prev_ff && !sda_prev_ff && sda_s;
   assign scl_rise = scl_s && !scl_prev_ff;
   assign scl_fall = !scl_s && scl_prev_ff;

   // bus busy tracking, free only a half bit after a stop
   logic busy_ff, free_pend_ff;
   logic [CNT_W-1:0] free_cnt_ff, half;
   assign half = fast_mode_in ? FAST_HALF_CYC : STD_HALF_CYC;

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         busy_ff <= 1'b0;
         free_pend_ff <= 1'b0;
         free_cnt_ff <= '0;
      end else if (start_det) begin
         busy_ff <= 1'b1;
         free_pend_ff <= 1'b0;
      end else if (stop_det) begin
         free_pend_ff <= 1'b1;
         free_cnt_ff <= half;
      end else if (free_pend_ff) begin
         if (free_cnt_ff == '0) begin
            busy_ff <= 1'b0;
            free_pend_ff <= 1'b0;
         end else begin
            free_cnt_ff <= free_cnt_ff - 1'b1;
         end
      end
   end

   // master engine
   mst_e mst_st_ff;
   logic [CNT_W-1:0] mst_cnt_ff;
   logic [3:0] mst_bit_ff;
   logic [8:0] mst_tx_ff, mst_rx_ff;
   logic mst_read_ff, mst_lost_ff, mst_own_ff, mst_hi_seen_ff, mst_stop_ff;
   logic mst_scl_low_ff, mst_sda_low_ff, rsp_valid_ff, rsp_nack_ff, arb_lost_ff, ready_ff;
   logic [7:0] rsp_data_ff;
   logic take, cnt_zero, mid, hi_end, own_bit, lose_now;

   assign take = cmd_valid_in && ready_ff && (mst_st_ff == M_IDLE || mst_st_ff == M_WAIT);
   assign cnt_zero = (mst_cnt_ff == '0);
   assign mid = (mst_cnt_ff == (half >> 1));
   // another participant pulling the clock low ends our high early
   assign hi_end = (mst_st_ff == M_HIGH) && mst_hi_seen_ff && (cnt_zero || !scl_s);
   assign own_bit = mst_read_ff ? (mst_bit_ff == ACK_BIT) : (mst_bit_ff != ACK_BIT);
   assign lose_now = own_bit && mst_tx_ff[8] && !sda_s && !mst_lost_ff;

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         mst_st_ff <= M_IDLE;
         mst_cnt_ff <= '0;
         mst_bit_ff <= '0;
         mst_tx_ff <= '0;
         mst_rx_ff <= '0;
         mst_read_ff <= 1'b0;
         mst_lost_ff <= 1'b0;
         mst_own_ff <= 1'b0;
         mst_hi_seen_ff <= 1'b0;
         mst_stop_ff <= 1'b0;
         mst_scl_low_ff <= 1'b0;
         mst_sda_low_ff <= 1'b0;
         rsp_valid_ff <= 1'b0;
         rsp_nack_ff <= 1'b0;
         rsp_data_ff <= '0;
         arb_lost_ff <= 1'b0;
      end else begin
         rsp_valid_ff <= 1'b0;
         arb_lost_ff <= 1'b0;
         unique case (mst_st_ff)
            M_IDLE: begin
               // other ops are accepted and dropped while idle
               if (take && cmd_op_in == OP_START) begin
                  mst_sda_low_ff <= 1'b1;
                  mst_cnt_ff <= half;
                  mst_own_ff <= 1'b1;
                  mst_lost_ff <= 1'b0;
                  mst_st_ff <= M_START;
               end
            end
            M_START: begin
               if (cnt_zero) begin
                  mst_scl_low_ff <= 1'b1;
                  rsp_valid_ff <= 1'b1;
                  mst_st_ff <= M_WAIT;
               end else begin
                  mst_cnt_ff <= mst_cnt_ff - 1'b1;
               end
            end
            M_WAIT: begin
               if (take) begin
                  mst_cnt_ff <= half;
                  mst_bit_ff <= '0;
                  unique case (cmd_op_in)
                     OP_START: mst_st_ff <= M_RSTART;
                     OP_STOP: mst_st_ff <= M_STOP_LOW;
                     OP_WRITE: begin
                        mst_tx_ff <= {cmd_data_in, 1'b1};
                        mst_read_ff <= 1'b0;
                        mst_st_ff <= M_LOW;
                     end
                     OP_READ: begin
                        mst_tx_ff <= {8'hFF, cmd_nack_in};
                        mst_read_ff <= 1'b1;
                        mst_st_ff <= M_LOW;
                     end
                  endcase
               end
            end
            M_LOW: begin
               mst_cnt_ff <= mst_cnt_ff - 1'b1;
               // data moves mid-low, well clear of either clock edge
               if (mid) begin
                  mst_sda_low_ff <= !mst_tx_ff[8] && !mst_lost_ff;
               end
               if (cnt_zero) begin
                  mst_scl_low_ff <= 1'b0;
                  mst_hi_seen_ff <= 1'b0;
                  mst_cnt_ff <= half;
                  mst_st_ff <= M_HIGH;
               end
            end
            M_HIGH: begin
               if (!mst_hi_seen_ff) begin
                  // a slower participant still holds the clock low
                  mst_hi_seen_ff <= scl_s;
               end else if (hi_end) begin
                  mst_scl_low_ff <= 1'b1;
                  mst_rx_ff <= {mst_rx_ff[7:0], sda_s};
                  mst_tx_ff <= {mst_tx_ff[7:0], 1'b1};
                  if (lose_now) begin
                     mst_lost_ff <= 1'b1;
                     mst_own_ff <= 1'b0;
                     arb_lost_ff <= 1'b1;
                  end
                  if (mst_bit_ff == ACK_BIT) begin
                     mst_bit_ff <= '0;
                     rsp_valid_ff <= 1'b1;
                     rsp_data_ff <= mst_rx_ff[7:0];
                     rsp_nack_ff <= sda_s;
                     if (mst_lost_ff || lose_now) begin
                        mst_scl_low_ff <= 1'b0;
                        mst_st_ff <= M_IDLE;
                     end else begin
                        mst_st_ff <= M_WAIT;
                     end
                  end else begin
                     mst_bit_ff <= mst_bit_ff + 1'b1;
                     mst_cnt_ff <= half;
                     mst_st_ff <= M_LOW;
                  end
               end else begin
                  mst_cnt_ff <= mst_cnt_ff - 1'b1;
               end
            end
            M_RSTART, M_STOP_LOW: begin
               mst_cnt_ff <= mst_cnt_ff - 1'b1;
               if (mid) begin
                  mst_sda_low_ff <= (mst_st_ff == M_STOP_LOW);
               end
               if (cnt_zero) begin
                  mst_stop_ff <= (mst_st_ff == M_STOP_LOW);
                  mst_scl_low_ff <= 1'b0;
                  mst_hi_seen_ff <= 1'b0;
                  mst_cnt_ff <= half;
                  mst_st_ff <= M_STOP_HIGH;
               end
            end
            M_STOP_HIGH: begin
               if (!mst_hi_seen_ff) begin
                  mst_hi_seen_ff <= scl_s;
               end else if (cnt_zero) begin
                  mst_sda_low_ff <= !mst_stop_ff;
                  mst_cnt_ff <= half;
                  mst_st_ff <= mst_stop_ff ? M_STOP_END : M_START;
               end else begin
                  mst_cnt_ff <= mst_cnt_ff - 1'b1;
               end
            end
            M_STOP_END: begin
               mst_cnt_ff <= mst_cnt_ff - 1'b1;
               if (cnt_zero) begin
                  mst_own_ff <= 1'b0;
                  rsp_valid_ff <= 1'b1;
                  mst_st_ff <= M_IDLE;
               end
            end
            default: mst_st_ff <= M_IDLE;
         endcase
      end
   end

   // slave engine, always decoding so a lost address phase still lands here
   slv_e slv_st_ff;
   logic [3:0] slv_bit_ff;
   logic [7:0] slv_sh_ff, slv_tx_ff, slv_rx_data_ff;
   logic slv_sda_low_ff, slv_stretch_ff, slv_match_ff, slv_rw_ff, slv_acc_ff, slv_mnack_ff;
   logic slv_rx_valid_ff, slv_tx_req_ff, addr_hit;
   assign addr_hit = (slv_sh_ff[7:1] == own_addr_in
      || (slv_sh_ff[7:1] == GEN_CALL_ADDR && !slv_sh_ff[0])) && !mst_own_ff;

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         slv_st_ff <= S_IDLE;
         slv_bit_ff <= '0;
         slv_sh_ff <= '0;
         slv_tx_ff <= '0;
         slv_rx_data_ff <= '0;
         slv_sda_low_ff <= 1'b0;
         slv_stretch_ff <= 1'b0;
         slv_match_ff <= 1'b0;
         slv_rw_ff <= 1'b0;
         slv_acc_ff <= 1'b0;
         slv_mnack_ff <= 1'b0;
         slv_rx_valid_ff <= 1'b0;
         slv_tx_req_ff <= 1'b0;
      end else begin
         slv_rx_valid_ff <= 1'b0;
         slv_tx_req_ff <= 1'b0;
         if (slv_stretch_ff && !slave_hold_in) begin
            slv_stretch_ff <= 1'b0;
         end
         if (start_det) begin
            slv_st_ff <= S_ADDR;
            // the clock fall that ends the start is no bit; it wraps this to 0
            slv_bit_ff <= '1;
            slv_sda_low_ff <= 1'b0;
            slv_stretch_ff <= 1'b0;
         end else if (stop_det) begin
            slv_st_ff <= S_IDLE;
            slv_sda_low_ff <= 1'b0;
            slv_stretch_ff <= 1'b0;
         end else if (slv_st_ff != S_IDLE && scl_rise) begin
            if (slv_bit_ff != ACK_BIT) begin
               slv_sh_ff <= {slv_sh_ff[6:0], sda_s};
            end else begin
               slv_mnack_ff <= sda_s;
            end
         end else if (slv_st_ff != S_IDLE && scl_fall) begin
            if (slv_bit_ff == BYTE_LAST_BIT) begin
               slv_bit_ff <= ACK_BIT;
               slv_sda_low_ff <= 1'b0;
               if (slv_st_ff == S_ADDR) begin
                  slv_sda_low_ff <= addr_hit;
                  slv_match_ff <= addr_hit;
                  slv_rw_ff <= slv_sh_ff[0];
               end else if (slv_st_ff == S_RX) begin
                  slv_rx_valid_ff <= 1'b1;
                  slv_rx_data_ff <= slv_sh_ff;
                  slv_sda_low_ff <= slave_rx_accept_in;
                  slv_acc_ff <= slave_rx_accept_in;
                  slv_stretch_ff <= slave_hold_in;
               end
            end else if (slv_bit_ff == ACK_BIT) begin
               slv_bit_ff <= '0;
               slv_sda_low_ff <= 1'b0;
               if ((slv_st_ff == S_ADDR && slv_match_ff && slv_rw_ff)
                     || (slv_st_ff == S_TX && !slv_mnack_ff)) begin
                  slv_st_ff <= S_TX;
                  slv_tx_ff <= slave_tx_data_in;
                  slv_tx_req_ff <= 1'b1;
                  slv_sda_low_ff <= !slave_tx_data_in[7];
               end else if (slv_st_ff == S_ADDR && slv_match_ff) begin
                  slv_st_ff <= S_RX;
               end else if (slv_st_ff != S_RX || !slv_acc_ff) begin
                  // unaddressed, refused, or master nacked our data
                  slv_st_ff <= S_SKIP;
               end
            end else begin
               slv_bit_ff <= slv_bit_ff + 1'b1;
               if (slv_st_ff == S_TX) begin
                  slv_tx_ff <= {slv_tx_ff[6:0], 1'b0};
                  slv_sda_low_ff <= !slv_tx_ff[6];
               end
            end
         end
      end
   end

   // pin and port flops
   logic scl_oe_ff, sda_oe_ff, scl_o_ff, sda_o_ff;
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         scl_oe_ff <= 1'b0;
         sda_oe_ff <= 1'b0;
         scl_o_ff <= 1'b0;
         sda_o_ff <= 1'b0;
         ready_ff <= 1'b0;
      end else begin
         scl_oe_ff <= mst_scl_low_ff || slv_stretch_ff;
         sda_oe_ff <= mst_sda_low_ff || slv_sda_low_ff;
         scl_o_ff <= 1'b0;
         sda_o_ff <= 1'b0;
         ready_ff <= !take && ((mst_st_ff == M_IDLE && !busy_ff) || mst_st_ff == M_WAIT);
      end
   end

   assign scl_out = scl_o_ff;
   assign sda_out = sda_o_ff;
   assign scl_oe_out = scl_oe_ff;
   assign sda_oe_out = sda_oe_ff;
   assign cmd_ready_out = ready_ff;
   assign rsp_valid_out = rsp_valid_ff;
   assign rsp_data_out = rsp_data_ff;
   assign rsp_nack_out = rsp_nack_ff;
   assign arb_lost_out = arb_lost_ff;
   assign bus_busy_out = busy_ff;
   assign slave_rx_valid_out = slv_rx_valid_ff;
   assign slave_rx_data_out = slv_rx_data_ff;
   assign slave_tx_req_out = slv_tx_req_ff;

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (reset_in);

   chk_pins_open_drain: assert property (!scl_out && !sda_out)
      else $error("pin driven high");
   chk_sda_stable_high: assert property (
      (mst_st_ff == M_HIGH && $past(mst_st_ff) == M_HIGH) |-> $stable(mst_sda_low_ff))
      else $error("master data moved while clock high");
   chk_start_shape: assert property (
      (mst_st_ff == M_START && $past(mst_st_ff) != M_START) |-> mst_sda_low_ff && !mst_scl_low_ff)
      else $error("start not data low under high clock");
   chk_stop_shape: assert property (
      (mst_st_ff == M_STOP_END && $past(mst_st_ff) == M_STOP_HIGH)
      |-> !mst_sda_low_ff && !mst_scl_low_ff && $past(mst_sda_low_ff))
      else $error("stop not data rise under high clock");
   chk_busy_after_start: assert property (start_det |=> busy_ff ##1 busy_ff)
      else $error("bus not busy after start");
   chk_byte_nine_clocks: assert property (
      (hi_end && mst_bit_ff == ACK_BIT)
      |=> (mst_st_ff == M_WAIT || mst_st_ff == M_IDLE) && mst_bit_ff == 4'h0 && rsp_valid_out)
      else $error("byte did not end after ack clock");
   chk_ack_released: assert property (
      (mst_st_ff == M_HIGH && !mst_read_ff && mst_bit_ff == ACK_BIT) |-> !mst_sda_low_ff)
      else $error("transmitter held data during ack");
   chk_slave_ack: assert property (
      (scl_fall && !start_det && !stop_det && slv_st_ff == S_RX
         && slv_bit_ff == BYTE_LAST_BIT && slave_rx_accept_in)
      |=> slv_sda_low_ff ##1 sda_oe_out)
      else $error("addressed receiver did not ack");
   chk_read_end_nack: assert property (
      (mst_st_ff == M_HIGH && mst_read_ff && mst_bit_ff == ACK_BIT && !mst_lost_ff)
      |-> mst_sda_low_ff == !mst_tx_ff[8])
      else $error("master receiver ack bit wrong");
   chk_stretch_holds: assert property (slv_stretch_ff |=> scl_oe_out)
      else $error("stretch not on clock pin");
   chk_shortest_high: assert property (
      (mst_st_ff == M_HIGH && mst_hi_seen_ff && !scl_s) |=> mst_scl_low_ff)
      else $error("master did not follow early clock fall");

   cov_write_nack: cover property (rsp_valid_out && rsp_nack_out);
   cov_arb_lost: cover property (arb_lost_out);
   cov_slave_rx: cover property (slave_rx_valid_out);
   cov_slave_tx: cover property (slave_tx_req_out);
endmodule

// ### verif/bus_device_model.sv
// behavioural addressed device sharing the two-wire bus with the controller
module bus_device_model #(
   parameter logic [6:0] DEV_ADDR = 7'h5a,
   parameter int STRETCH_NS = 4000
) (
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic ack_en_in,
   input wire logic stretch_in,
   input wire logic contend_in,
   input wire logic [7:0] rd_byte_in,
   output logic scl_oe_out = 1'b0,
   output logic sda_oe_out = 1'b0,
   output logic [7:0] rx_byte_out = 8'h00,
   output logic ack_lvl_out = 1'b1
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] sh = 8'h00;
   logic restart = 1'b0;
   logic cond, adr, rd, first;
   // pull only; change well after the clock fell so no edge races it
   task automatic put(input logic v);
      #300 sda_oe_out = v;
   endtask
   always begin
      if (!restart) @(negedge sda_in iff scl_in === 1'b1); // start
      {cond, adr, rd, first, restart} = 5'b00010;
      @(negedge scl_in);
      while (!cond) begin
         for (int i = 7; i >= 0 && !cond; i--) begin
            if (first && contend_in) put(1'b1);
            else if (rd && adr) put(!rd_byte_in[i]); // msb first
            @(posedge scl_in);
            sh[i] = sda_in;
            @(negedge scl_in or sda_in);
            cond = scl_in; // data moved while clock high
         end
         if (!cond) begin
            if (first) {adr, rd} = {sh[7:1] == DEV_ADDR, sh[0]};
            else if (!rd) rx_byte_out = sh;
            // receiver acks, transmitter lets go
            put((first || !rd) && adr && (first || ack_en_in));
            @(posedge scl_in);
            ack_lvl_out = sda_in;
            if (rd && !first && sda_in) adr = 1'b0; // quiet after a nack
            @(negedge scl_in);
            put(1'b0);
            if (stretch_in) begin
               scl_oe_out = 1'b1; // slow receiver
               #STRETCH_NS scl_oe_out = 1'b0;
            end
            first = 1'b0;
         end
      end
      restart = !sda_in; // repeated start has already fallen
      sda_oe_out = 1'b0;
   end
endmodule

// ### verif/test_two_wire_bus_controller.sv
// self-checking bench for the two-wire bus controller
module test_two_wire_bus_controller
   import two_wire_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [6:0] DEV = 7'h5a;
   localparam int STRETCH_NS = 4000;
   // stretch begins a little after the fall, hence the slack
   localparam int LIM = STRETCH_NS / 10 - 40 + 17 * int'(FAST_HALF_CYC);
   typedef struct packed {
      logic fast;
      logic [7:0] abyte;
      logic [7:0] dbyte;
      logic ack_en;
      logic anack;
      logic dnack;
   } row_s;
   row_s rows [5] = '{
      '{1'b1, {DEV, 1'b0}, 8'ha5, 1'b1, 1'b0, 1'b0},
      '{1'b1, {DEV, 1'b1}, 8'h3c, 1'b1, 1'b0, 1'b1},
      '{1'b1, {7'h11, 1'b0}, 8'h00, 1'b1, 1'b1, 1'b1},
      '{1'b1, {DEV, 1'b0}, 8'h81, 1'b0, 1'b0, 1'b1},
      '{1'b0, {DEV, 1'b0}, 8'h5e, 1'b1, 1'b0, 1'b0}
   };
   logic clk_in = 1'b0;
   logic reset_in = 1'b1;
   logic fast = 1'b1, cmd_valid = 1'b0, cmd_nack = 1'b0, got_arb = 1'b0;
   logic ack_en = 1'b1, stretch = 1'b0, contend = 1'b0;
   op_e cmd_op = OP_START;
   logic [7:0] cmd_data = 8'h00, rd_byte = 8'h00, rsp_data, m_rx;
   logic scl_oe, sda_oe, m_scl_oe, m_sda_oe, ready, rsp_valid, rsp_nack, arb_lost, busy;
   logic m_ack, scl, sda;
   int n_fail = 0, checks = 0, cyc = 0, lat = 0, byte_lat = 0;
   // wired-and lines with pull-ups
   assign scl = !(scl_oe || m_scl_oe);
   assign sda = !(sda_oe || m_sda_oe);
   two_wire_ctrl i_dut (
      .clk_in(clk_in), .reset_in(reset_in), .scl_in(scl), .scl_out(), .scl_oe_out(scl_oe),
      .sda_in(sda), .sda_out(), .sda_oe_out(sda_oe), .fast_mode_in(fast),
      .cmd_valid_in(cmd_valid), .cmd_ready_out(ready), .cmd_op_in(cmd_op),
      .cmd_data_in(cmd_data), .cmd_nack_in(cmd_nack), .rsp_valid_out(rsp_valid),
      .rsp_data_out(rsp_data), .rsp_nack_out(rsp_nack), .arb_lost_out(arb_lost),
      .bus_busy_out(busy), .own_addr_in(7'h2c), .slave_rx_valid_out(),
      .slave_rx_data_out(), .slave_rx_accept_in(1'b1), .slave_hold_in(1'b0),
      .slave_tx_data_in(8'h00), .slave_tx_req_out()
   );
   bus_device_model #(.DEV_ADDR(DEV), .STRETCH_NS(STRETCH_NS)) i_dev (
      .scl_in(scl), .sda_in(sda), .ack_en_in(ack_en), .stretch_in(stretch),
      .contend_in(contend), .rd_byte_in(rd_byte), .scl_oe_out(m_scl_oe),
      .sda_oe_out(m_sda_oe), .rx_byte_out(m_rx), .ack_lvl_out(m_ack)
   );
   initial begin
      forever #5 clk_in = !clk_in;
   end
   // about twice the expected run
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         n_fail++;
         test_done();
      end
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic cmd(input op_e op, input logic [7:0] d, input logic nk);
      cmd_op <= op;
      cmd_data <= d;
      cmd_nack <= nk;
      cmd_valid <= 1'b1;
      do @(posedge clk_in); while (ready !== 1'b1);
      cmd_valid <= 1'b0;
      lat = 0;
      got_arb = 1'b0;
      do begin
         @(posedge clk_in);
         lat++;
         got_arb |= arb_lost;
      end while (rsp_valid !== 1'b1);
   endtask
   task automatic frame(input row_s r);
      fast <= r.fast;
      ack_en <= r.ack_en;
      rd_byte <= r.dbyte;
      cmd(OP_START, 8'h00, 1'b0);
      check({7'h00, busy}, 8'h01);
      cmd(OP_WRITE, r.abyte, 1'b0);
      check({7'h00, rsp_nack}, {7'h00, r.anack});
      if (!r.anack && r.abyte[0]) begin
         cmd(OP_READ, 8'h00, 1'b1);
         check(rsp_data, r.dbyte);
         check({7'h00, m_ack}, 8'h01);
      end else if (!r.anack) begin
         cmd(OP_WRITE, r.dbyte, 1'b0);
         check({7'h00, rsp_nack}, {7'h00, r.dnack});
         check(m_rx, r.dbyte);
      end
      byte_lat = lat;
      cmd(OP_STOP, 8'h00, 1'b0);
      repeat (r.fast ? FAST_HALF_CYC + 20 : STD_HALF_CYC + 20) @(posedge clk_in);
      check({7'h00, busy}, 8'h00);
      check({7'h00, sda}, 8'h01);
   endtask
   task automatic reset_dut();
      reset_in <= 1'b1;
      repeat (10) @(posedge clk_in);
      check({4'h0, scl_oe, sda_oe, busy, ready}, 8'h00);
      reset_in <= 1'b0;
      repeat (4) @(posedge clk_in);
      check({7'h00, ready}, 8'h01);
      $display("reset test done");
   endtask
   initial begin
      reset_dut();
      foreach (rows[k]) begin
         frame(rows[k]);
         $display("row test %0d done", k);
      end
      stretch <= 1'b1;
      frame(rows[0]);
      check({7'h00, byte_lat >= LIM}, 8'h01);
      $display("stretch test done");
      stretch <= 1'b0;
      contend <= 1'b1;
      cmd(OP_START, 8'h00, 1'b0);
      cmd(OP_WRITE, {DEV, 1'b0}, 1'b0);
      check({7'h00, got_arb}, 8'h01);
      check({7'h00, lat >= 17 * int'(FAST_HALF_CYC)}, 8'h01);
      check({7'h00, m_ack}, 8'h00);
      repeat (FAST_HALF_CYC) @(posedge clk_in);
      check({7'h00, scl_oe}, 8'h00);
      $display("arbitration test done");
      contend <= 1'b0;
      reset_dut();
      test_done();
   end
endmodule
